// ### core/btfb_pkg.sv
package btfb_pkg;
  // ==========================================================================
  // opcode decoding
  // ==========================================================================
  localparam logic [3:0] BIT_INVERT_OPC = 4'h7;
  localparam logic [7:0] BRANCH_IF_OVERFLOW_OPC = 8'he4;
  localparam logic [7:0] BRANCH_IF_ZERO_OPC = 8'he0;
  localparam int BIT_SEL_LSB = 9;
  localparam int BANK_ACCESS_POS = 8;
  localparam logic [3:0] ACCESS_BANK_NUM = 4'h0;
  localparam logic [7:0] ACCESS_SPLIT_ADDR = 8'h80;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  // ==========================================================================
  // reset values and timing
  // ==========================================================================
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q3 = 2'h2;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [3:0] BANK_RESET = 4'h0;

  typedef enum logic [1:0] {
    BTFB_EXEC = 2'b00,
    BTFB_IDLE_CYC = 2'b01
  } btfb_state_t;
endpackage : btfb_pkg

// ### core/btfb_phase_gen.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// four-phase instruction cycle counter
// ==========================================================================
module btfb_phase_gen (
  input wire logic mclk_in,
  input wire logic rst_in,
  output logic [1:0] phase_out,
  output logic cycle_end_out
);
  logic [1:0] phase_r;
  logic [1:0] phase_nxt;

  always_comb begin
    phase_nxt = phase_r + 2'h1;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_r <= btfb_pkg::PHASE_Q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign phase_out = phase_r;
  assign cycle_end_out = (phase_r == btfb_pkg::PHASE_Q4);
endmodule : btfb_phase_gen
`default_nettype wire

// ### core/btfb_exec.sv
// Behaviour
// RULE1: top nibble 0111 is bit invert; bit, access bit, file address fields.
// RULE2: bit invert flips only the chosen bit and writes the byte back.
// RULE3: access bit 0 uses access bank; 1 uses bank select register.
// RULE4: upper byte 1110 0100 is branch on overflow; low byte signed offset.
// RULE5: overflow branch taken only when overflow flag is one.
// RULE6: upper byte 1110 0000 is branch on zero with signed offset.
// RULE7: zero branch taken only when zero flag is one.
// RULE8: taken target is incremented pc plus twice sign-extended offset.
// RULE9: offset spans minus 128 to plus 127 words.
// RULE10: untaken branch one cycle; taken two, pc written in q4, then idle.
// RULE11: no status flag changes; bit invert done within one cycle.
`timescale 1ns/10ps
`default_nettype none
module btfb_exec (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [15:0] instr_in,
  input wire logic [3:0] bank_select_reg_in,
  input wire logic overflow_flag_in,
  input wire logic zero_flag_in,
  input wire logic [7:0] dmem_rdata_in,
  output logic [1:0] phase_out,
  output logic [20:0] pc_out,
  output logic [11:0] dmem_addr_out,
  output logic dmem_rd_out,
  output logic dmem_wr_out,
  output logic [7:0] dmem_wdata_out,
  output logic fetch_out,
  output logic status_wr_out
);
  // ==========================================================================
  // phase sequencing
  // ==========================================================================
  logic [1:0] phase;
  logic cycle_end;

  btfb_phase_gen u_phase (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .phase_out(phase),
    .cycle_end_out(cycle_end)
  );

  // ==========================================================================
  // decode
  // ==========================================================================
  logic is_invert;
  logic is_bov;
  logic is_bz;
  logic [2:0] bit_sel;
  logic [11:0] eff_addr;
  logic take;
  logic [20:0] target;
  logic [20:0] offs2;
  logic [20:0] pc_r;
  logic [20:0] pc_nxt;

  always_comb begin
    is_invert = (instr_in[15:12] == btfb_pkg::BIT_INVERT_OPC); // see RULE1
    is_bov = (instr_in[15:8] == btfb_pkg::BRANCH_IF_OVERFLOW_OPC); // see RULE4
    is_bz = (instr_in[15:8] == btfb_pkg::BRANCH_IF_ZERO_OPC); // see RULE6
    bit_sel = instr_in[btfb_pkg::BIT_SEL_LSB +: 3]; // see RULE1
    // access bank: low half in bank 0, high half maps to the sfr bank
    if (instr_in[btfb_pkg::BANK_ACCESS_POS]) begin
      eff_addr = {bank_select_reg_in, instr_in[7:0]}; // see RULE3
    end else if (instr_in[7:0] < btfb_pkg::ACCESS_SPLIT_ADDR) begin
      eff_addr = {btfb_pkg::ACCESS_BANK_NUM, instr_in[7:0]}; // see RULE3
    end else begin
      eff_addr = {btfb_pkg::ACCESS_HIGH_BANK, instr_in[7:0]}; // see RULE3
    end
    // see RULE5 RULE7
    take = (is_bov && overflow_flag_in) || (is_bz && zero_flag_in);
    // sign-extend then double: covers -128..127 words, see RULE9
    offs2 = {{12{instr_in[7]}}, instr_in[7:0], 1'b0};
    target = pc_r + offs2; // see RULE8
  end

  // ==========================================================================
  // state, pc and data memory strobes
  // ==========================================================================
  btfb_pkg::btfb_state_t state_r;
  btfb_pkg::btfb_state_t state_nxt;
  logic [11:0] addr_r;
  logic [11:0] addr_nxt;
  logic rd_r;
  logic rd_nxt;
  logic wr_r;
  logic wr_nxt;
  logic [7:0] wdata_r;
  logic [7:0] wdata_nxt;
  logic fetch_r;
  logic fetch_nxt;
  logic status_wr_r;
  logic status_wr_nxt;
  logic [1:0] phase_r;

  // pc_r is the already incremented address during execution
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    addr_nxt = addr_r;
    rd_nxt = 1'b0;
    wr_nxt = 1'b0;
    wdata_nxt = wdata_r;
    fetch_nxt = 1'b0;
    status_wr_nxt = 1'b0; // see RULE11
    case (state_r)
      btfb_pkg::BTFB_EXEC: begin
        if (phase == btfb_pkg::PHASE_Q1 && is_invert) begin
          addr_nxt = eff_addr; // see RULE3
          rd_nxt = 1'b1;
        end
        if (phase == btfb_pkg::PHASE_Q3 && is_invert) begin
          // single-cycle read-modify-write, see RULE11
          wdata_nxt = dmem_rdata_in ^ (8'h01 << bit_sel); // see RULE2
          wr_nxt = 1'b1; // see RULE2
        end
        if (cycle_end) begin
          fetch_nxt = 1'b1;
          if (take) begin
            pc_nxt = target; // see RULE10
            state_nxt = btfb_pkg::BTFB_IDLE_CYC; // see RULE10
          end else begin
            pc_nxt = pc_r + btfb_pkg::PC_STEP; // see RULE10
          end
        end
      end
      btfb_pkg::BTFB_IDLE_CYC: begin
        // flushed cycle: fetch refills from the new target
        if (cycle_end) begin
          fetch_nxt = 1'b1;
          pc_nxt = pc_r + btfb_pkg::PC_STEP;
          state_nxt = btfb_pkg::BTFB_EXEC;
        end
      end
      default: begin
        state_nxt = btfb_pkg::BTFB_EXEC;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= btfb_pkg::BTFB_EXEC;
      pc_r <= btfb_pkg::PC_RESET;
      addr_r <= 12'h000;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      wdata_r <= 8'h00;
      fetch_r <= 1'b0;
      status_wr_r <= 1'b0;
      phase_r <= btfb_pkg::PHASE_Q1;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      addr_r <= addr_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      wdata_r <= wdata_nxt;
      fetch_r <= fetch_nxt;
      status_wr_r <= status_wr_nxt;
      phase_r <= phase;
    end
  end

  assign phase_out = phase_r;
  assign pc_out = pc_r;
  assign dmem_addr_out = addr_r;
  assign dmem_rd_out = rd_r;
  assign dmem_wr_out = wr_r;
  assign dmem_wdata_out = wdata_r;
  assign fetch_out = fetch_r;
  assign status_wr_out = status_wr_r; // see RULE11

  // ==========================================================================
  // checks
  // ==========================================================================
  sequence taken_q4;
    state_r == btfb_pkg::BTFB_EXEC && cycle_end && take;
  endsequence

  sequence idle_cycle;
    (state_r == btfb_pkg::BTFB_IDLE_CYC) [*4];
  endsequence

  chk_taken_idle_cyc: assert property (@(posedge mclk_in) disable iff (rst_in)
    taken_q4 |=> idle_cycle ##1 state_r == btfb_pkg::BTFB_EXEC) // see RULE10
    else $error("taken branch not followed by one idle cycle");

  chk_branch_target: assert property (@(posedge mclk_in) disable iff (rst_in)
    taken_q4 |=> pc_r == $past(target)) // see RULE8
    else $error("branch target wrong");

  chk_untaken_step: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == btfb_pkg::BTFB_EXEC && cycle_end && !take
    |=> pc_r == $past(pc_r) + btfb_pkg::PC_STEP) // see RULE10
    else $error("untaken branch did not step pc");

  chk_bov_cond: assert property (@(posedge mclk_in) disable iff (rst_in)
    is_bov && !overflow_flag_in && !is_bz |-> !take) // see RULE5
    else $error("overflow branch taken with flag clear");

  chk_bz_cond: assert property (@(posedge mclk_in) disable iff (rst_in)
    is_bz && zero_flag_in |-> take) // see RULE7
    else $error("zero branch not taken with flag set");

  chk_invert_one_bit: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == btfb_pkg::BTFB_EXEC && phase == btfb_pkg::PHASE_Q3 && is_invert
    |=> wr_r && $countones(wdata_r ^ $past(dmem_rdata_in)) == 1) // see RULE2
    else $error("bit invert changed other than one bit");

  chk_access_bank: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == btfb_pkg::BTFB_EXEC && phase == btfb_pkg::PHASE_Q1 && is_invert
    && !instr_in[8] && instr_in[7:0] < 8'h80
    |=> rd_r && addr_r[11:8] == 4'h0) // see RULE3
    else $error("access bank not used");

  chk_decode_invert: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == btfb_pkg::BTFB_EXEC && phase == btfb_pkg::PHASE_Q1
    && instr_in[15:12] == 4'h7 |=> rd_r) // see RULE1
    else $error("bit invert decode wrong");

  chk_no_status_wr: assert property (@(posedge mclk_in) disable iff (rst_in)
    !status_wr_out) // see RULE11
    else $error("status written");

  chk_rmw_one_cycle: assert property (@(posedge mclk_in) disable iff (rst_in)
    rd_r |-> ##2 wr_r) // see RULE11
    else $error("write-back not in same instruction cycle");
endmodule : btfb_exec
`default_nettype wire

// ### verif/btfb_dmem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// data memory behind the executor
// ==========================================================================
module btfb_dmem_model (
  input wire logic mclk_in,
  input wire logic [11:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:4095];
  logic valid_r = 1'b0;
  // outside the read slot the lines show a wrong value, not the byte
  assign rdata_out = valid_r ? mem[addr_in] : ~mem[addr_in];
  always @(posedge mclk_in) begin
    valid_r <= rd_in;
    if (wr_in) begin
      mem[addr_in] <= wdata_in;
    end
  end
endmodule : btfb_dmem_model
`default_nettype wire

// ### verif/bit_toggle_and_flag_branch_exec_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// self-checking bench
// ==========================================================================
module bit_toggle_and_flag_branch_exec_tb;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] instr = 16'h0000;
  logic [3:0] bank_select_reg = 4'h0;
  logic ovf = 1'b0;
  logic zf = 1'b0;
  logic [7:0] rdata, wdata, f, v, off;
  logic [20:0] pc, pc0, exp_pc;
  logic [11:0] addr, ea;
  logic [1:0] phase;
  logic rd, wr, fetch, st_wr, acc, op, fl;
  logic [2:0] b;
  logic [7:0] tab [4] = '{8'h7f, 8'h80, 8'h00, 8'hff};
  int n_errors = 0;
  int cmp_count = 0;
  int cyc, nw, nr;
  always #5 mclk_in = ~mclk_in;
  btfb_exec uut (.mclk_in(mclk_in), .rst_in(rst_in), .instr_in(instr),
    .bank_select_reg_in(bank_select_reg), .overflow_flag_in(ovf), .zero_flag_in(zf),
    .dmem_rdata_in(rdata), .phase_out(phase), .pc_out(pc),
    .dmem_addr_out(addr), .dmem_rd_out(rd), .dmem_wr_out(wr),
    .dmem_wdata_out(wdata), .fetch_out(fetch), .status_wr_out(st_wr));
  btfb_dmem_model dm (.mclk_in(mclk_in), .addr_in(addr), .rd_in(rd),
    .wr_in(wr), .wdata_in(wdata), .rdata_out(rdata));
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  // clocks and data writes up to the next fetch pulse, bounded
  task automatic wait_fetch();
    cyc = 0;
    nw = 0;
    nr = 0;
    do begin
      @(posedge mclk_in);
      #1;
      cyc++;
      nw += (wr === 1'b1);
      nr += (rd === 1'b1);
      check("status write", st_wr, 0);
    end while (fetch !== 1'b1 && cyc < 12);
    if (fetch !== 1'b1) begin
      check("fetch wait", 0, 1);
      final_report();
    end
  endtask : wait_fetch
  initial begin
    void'($urandom(32'h69cf));
    repeat (8) @(posedge mclk_in);
    #1 rst_in = 1'b0;
    wait_fetch();
    for (int i = 0; i < 24; i++) begin
      f = (i < 4) ? tab[i] : 8'($urandom);
      acc = (i < 4) ? 1'b0 : 1'($urandom);
      b = 3'($urandom);
      bank_select_reg = 4'($urandom);
      {ovf, zf} = 2'($urandom);
      ea = acc ? {bank_select_reg, f} : {(f < 8'h80) ? 4'h0 : 4'hf, f};
      v = 8'($urandom);
      dm.mem[ea] = v;
      pc0 = pc;
      instr = {4'h7, b, acc, f};
      wait_fetch();
      check("toggle cycles", cyc, 4);
      check("toggle writes", nw, 1);
      check("toggle reads", nr, 1);
      check("fetch phase", phase, 2'h3);
      check("toggle addr", addr, ea);
      check("toggled byte", dm.mem[ea], v ^ (8'h01 << b));
      check("toggle pc", pc, pc0 + 21'h2);
    end
    for (int i = 0; i < 32; i++) begin
      op = i[0];
      fl = (i < 8) ? i[1] : 1'($urandom);
      off = (i < 8) ? tab[{i[2], i[0]}] : 8'($urandom);
      // the other flag is set opposite so a wrong flag choice shows
      ovf = op ? fl : ~fl;
      zf = op ? ~fl : fl;
      pc0 = pc;
      instr = {op ? 8'he4 : 8'he0, off};
      exp_pc = fl ? pc0 + {{12{off[7]}}, off, 1'b0} : pc0 + 21'h2;
      wait_fetch();
      check("branch cycles", cyc, 4);
      check("branch pc", pc, exp_pc);
      check("branch writes", nw, 0);
      check("branch reads", nr, 0);
      check("branch phase", phase, 2'h3);
      if (fl) begin
        wait_fetch();
        check("idle cycles", cyc, 4);
        check("idle pc", pc, exp_pc + 21'h2);
      end
    end
    final_report();
  end
endmodule : bit_toggle_and_flag_branch_exec_tb
`default_nettype wire
